// [hdl/pdp_device.sv]
/*
 * Port D (8 pins) and port E (3 pins) with direction, output latches,
 * pin readback and a parallel slave port using port E as strobes.
 * Assumes a CPU register port on clock_in and asynchronous pins
 * arriving through pdp_if.
 */
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
module pdp_device
    import pdp_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    pdp_if.dev pins,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out
);
    // ----------------------------------------------------------------
    // Pin input synchronisers
    // ----------------------------------------------------------------
    logic [10:0] s1_r;
    logic [10:0] s2_r;
    logic [10:0] s3_r;
    logic [10:0] filt_r;
    logic [7:0] d_pin;
    logic [2:0] e_pin;

    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s1_r <= PIN_IDLE;
            s2_r <= PIN_IDLE;
            s3_r <= PIN_IDLE;
            filt_r <= PIN_IDLE;
        end else begin
            s1_r <= {pins.e_level, pins.d_level};
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
        end
    end
    assign d_pin = filt_r[7:0];
    assign e_pin = filt_r[10:8];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] d_lat_r;
    logic [7:0] d_dir_r;
    logic [2:0] e_lat_r;
    logic [2:0] e_dir_r;
    logic [7:0] ana_cfg_r;
    logic [7:0] in_byte_r;
    logic slave_en_r;
    logic in_full_r;
    logic out_pend_r;
    logic overrun_r;
    logic e_digital;
    logic cpu_wr_dpin;
    logic cpu_rd_dpin;
    logic cpu_wr_ctrl;

    assign e_digital = (ana_cfg_r[2:0] == ANA_DIGITAL);
    assign cpu_wr_dpin = wr_in && (addr_in == REG_D_PIN);
    assign cpu_rd_dpin = rd_in && (addr_in == REG_D_PIN);
    assign cpu_wr_ctrl = wr_in && (addr_in == REG_E_CTRL);

    // Output latches; pin-register writes also land in the latch
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            d_lat_r <= D_LAT_RST;
            e_lat_r <= E_LAT_RST;
        end else if (wr_in) begin
            if (addr_in == REG_D_PIN || addr_in == REG_D_LAT)
                d_lat_r <= wdata_in;
            if (addr_in == REG_E_PIN || addr_in == REG_E_LAT)
                e_lat_r <= wdata_in[2:0];
        end
    end

    // Direction and configuration registers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            d_dir_r <= D_DIR_RST;
            e_dir_r <= E_DIR_RST;
            slave_en_r <= 1'b0;
            ana_cfg_r <= ANA_CFG_RST;
        end else if (wr_in) begin
            if (addr_in == REG_D_DIR)
                d_dir_r <= wdata_in;
            if (cpu_wr_ctrl) begin
                e_dir_r <= wdata_in[2:0];
                slave_en_r <= wdata_in[CTRL_SLAVE_EN];
            end
            if (addr_in == REG_ANA_CFG)
                ana_cfg_r <= wdata_in & ANA_CFG_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Slave port strobes
    // ----------------------------------------------------------------
    logic chip_sel;
    logic wr_sel;
    logic rd_sel;
    logic wr_sel_q_r;
    logic rd_sel_q_r;
    logic ext_wr;
    logic ext_rd;

    // Strobes count only under select; held-low strobes act once
    assign chip_sel = slave_en_r && !e_pin[E_CS_BIT];
    assign wr_sel = chip_sel && !e_pin[E_WR_BIT];
    assign rd_sel = chip_sel && !e_pin[E_RD_BIT];
    assign ext_wr = wr_sel && !wr_sel_q_r;
    assign ext_rd = rd_sel && !rd_sel_q_r;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wr_sel_q_r <= 1'b0;
            rd_sel_q_r <= 1'b0;
        end else begin
            wr_sel_q_r <= wr_sel;
            rd_sel_q_r <= rd_sel;
        end
    end

    // Byte written by the external master
    always_ff @(posedge clock_in) begin
        if (rst_in)
            in_byte_r <= 8'h00;
        else if (ext_wr)
            in_byte_r <= d_pin;
    end

    // Status flags; a hardware set beats a same-cycle clear
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            in_full_r <= 1'b0;
            out_pend_r <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            if (ext_wr)
                in_full_r <= 1'b1;
            else if (cpu_rd_dpin && slave_en_r)
                in_full_r <= 1'b0;
            if (cpu_wr_dpin && slave_en_r)
                out_pend_r <= 1'b1;
            else if (ext_rd)
                out_pend_r <= 1'b0;
            if (ext_wr && in_full_r)
                overrun_r <= 1'b1;
            else if (cpu_wr_ctrl && !wdata_in[CTRL_OVERRUN])
                overrun_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    // Slave mode releases D except while a selected read is low
    assign pins.d_dev_out = d_lat_r;
    assign pins.d_dev_oe = slave_en_r ? {8{rd_sel}} : ~d_dir_r;
    // Direction rules even in analog use, so software must keep 1s
    assign pins.e_dev_out = e_lat_r;
    assign pins.e_dev_oe = ~e_dir_r;

    // ----------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------------------------------
    logic [7:0] rd_nxt;

    always_comb begin
        rd_nxt = 8'h00;
        unique case (addr_in)
            REG_D_PIN: rd_nxt = slave_en_r ? in_byte_r : d_pin;
            REG_D_LAT: rd_nxt = d_lat_r;
            REG_D_DIR: rd_nxt = d_dir_r;
            REG_E_CTRL: rd_nxt = {in_full_r, out_pend_r, overrun_r,
                                  slave_en_r, 1'b0, e_dir_r};
            REG_E_PIN: rd_nxt = {5'h00, e_pin & {3{e_digital}}};
            REG_E_LAT: rd_nxt = {5'h00, e_lat_r};
            REG_ANA_CFG: rd_nxt = ana_cfg_r;
            default: rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in)
            rdata_out <= 8'h00;
        else if (rd_in)
            rdata_out <= rd_nxt;
        else
            rdata_out <= 8'h00;
    end
endmodule : pdp_device

// [hdl/pdp_pkg.sv]
/*
 * Shared constants for the port D/E block with slave-port control:
 * CPU register indices, reset values, field positions, link timing.
 * Assumes both ends and the bench compile this package first.
 */
package pdp_pkg;
    // ----------------------------------------------------------------
    // CPU register indices (3-bit address)
    // ----------------------------------------------------------------
    localparam logic [2:0] REG_D_PIN = 3'h0;
    localparam logic [2:0] REG_D_LAT = 3'h1;
    localparam logic [2:0] REG_D_DIR = 3'h2;
    localparam logic [2:0] REG_E_CTRL = 3'h3;
    localparam logic [2:0] REG_E_PIN = 3'h4;
    localparam logic [2:0] REG_E_LAT = 3'h5;
    localparam logic [2:0] REG_ANA_CFG = 3'h6;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] D_DIR_RST = 8'hFF;
    localparam logic [7:0] D_LAT_RST = 8'h00;
    localparam logic [2:0] E_DIR_RST = 3'h7;
    localparam logic [2:0] E_LAT_RST = 3'h0;
    localparam logic [7:0] ANA_CFG_RST = 8'h00;
    localparam logic [7:0] ANA_CFG_MASK = 8'hCF;
    localparam logic [10:0] PIN_IDLE = 11'h7FF;

    // ----------------------------------------------------------------
    // Control register fields and pin roles
    // ----------------------------------------------------------------
    localparam int CTRL_IN_FULL = 7;
    localparam int CTRL_OUT_PEND = 6;
    localparam int CTRL_OVERRUN = 5;
    localparam int CTRL_SLAVE_EN = 4;
    localparam int E_RD_BIT = 0;
    localparam int E_WR_BIT = 1;
    localparam int E_CS_BIT = 2;
    localparam logic [2:0] ANA_DIGITAL = 3'h7;

    // ----------------------------------------------------------------
    // External bus master timing, in clock_in cycles
    // ----------------------------------------------------------------
    localparam logic [3:0] HOST_SETUP_CYC = 4'h2;
    localparam logic [3:0] HOST_ACT_CYC = 4'hA;
    localparam logic [3:0] HOST_HOLD_CYC = 4'h2;

    typedef enum logic [1:0] {
        HS_IDLE,
        HS_SETUP,
        HS_ACT,
        HS_HOLD
    } pdp_hstate_t;
endpackage : pdp_pkg

// [hdl/pdp_if.sv]
/*
 * Pin carrier between the port device and the external bus master.
 * Resolves each wire from both drivers' enables; undriven pins pull
 * high, as an external pull-up would.
 */
`timescale 1ns/100ps
interface pdp_if;
    logic [7:0] d_dev_out;
    logic [7:0] d_dev_oe;
    logic [7:0] d_host_out;
    logic [7:0] d_host_oe;
    logic [2:0] e_dev_out;
    logic [2:0] e_dev_oe;
    logic [2:0] e_host_out;
    logic [2:0] e_host_oe;
    logic [7:0] d_level;
    logic [2:0] e_level;

    // Device wins a contention; the bench flags overlap on port D only
    assign d_level = (d_dev_oe & d_dev_out)
                   | (~d_dev_oe & d_host_oe & d_host_out)
                   | (~d_dev_oe & ~d_host_oe);
    assign e_level = (e_dev_oe & e_dev_out)
                   | (~e_dev_oe & e_host_oe & e_host_out)
                   | (~e_dev_oe & ~e_host_oe);

    modport dev (
        output d_dev_out, d_dev_oe, e_dev_out, e_dev_oe,
        input d_level, e_level
    );
    modport host (
        output d_host_out, d_host_oe, e_host_out, e_host_oe,
        input d_level, e_level
    );
endinterface : pdp_if

// [hdl/pdp_host.sv]
/*
 * External 8-bit bus master for the slave port: drives chip select,
 * read and write strobes on port E and data on port D.
 * Assumes the device has slave mode on, port E inputs and digital.
 */
`timescale 1ns/100ps
module pdp_host
    import pdp_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    pdp_if.host pins,
    input wire logic bus_en_in,
    input wire logic wr_req_in,
    input wire logic rd_req_in,
    input wire logic [7:0] wdata_in,
    output logic busy_out,
    output logic [7:0] rdata_out,
    output logic rdone_out
);
    // ----------------------------------------------------------------
    // Data pin synchroniser
    // ----------------------------------------------------------------
    logic [7:0] s1_r;
    logic [7:0] s2_r;
    logic [7:0] s3_r;
    logic [7:0] filt_r;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s1_r <= 8'hFF;
            s2_r <= 8'hFF;
            s3_r <= 8'hFF;
            filt_r <= 8'hFF;
        end else begin
            s1_r <= pins.d_level;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
        end
    end

    // ----------------------------------------------------------------
    // Access sequencer
    // ----------------------------------------------------------------
    pdp_hstate_t state_r;
    logic [3:0] cnt_r;
    logic is_wr_r;
    logic [7:0] wdata_r;

    // Long strobe covers both ends' synchronisers plus the turnaround
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_r <= HS_IDLE;
            cnt_r <= 4'h0;
            is_wr_r <= 1'b0;
            wdata_r <= 8'h00;
        end else begin
            unique case (state_r)
                HS_IDLE: if (wr_req_in || rd_req_in) begin
                    state_r <= HS_SETUP;
                    is_wr_r <= wr_req_in;
                    wdata_r <= wdata_in;
                    cnt_r <= HOST_SETUP_CYC - 4'h1;
                end
                HS_SETUP: if (cnt_r == 4'h0) begin
                    state_r <= HS_ACT;
                    cnt_r <= HOST_ACT_CYC - 4'h1;
                end else begin
                    cnt_r <= cnt_r - 4'h1;
                end
                HS_ACT: if (cnt_r == 4'h0) begin
                    state_r <= HS_HOLD;
                    cnt_r <= HOST_HOLD_CYC - 4'h1;
                end else begin
                    cnt_r <= cnt_r - 4'h1;
                end
                HS_HOLD: if (cnt_r == 4'h0)
                    state_r <= HS_IDLE;
                else
                    cnt_r <= cnt_r - 4'h1;
            endcase
        end
    end

    // Read byte sampled at the end of the strobe
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
            rdone_out <= 1'b0;
        end else begin
            rdone_out <= 1'b0;
            if (state_r == HS_ACT && cnt_r == 4'h0 && !is_wr_r) begin
                rdata_out <= filt_r;
                rdone_out <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers (strobes active low)
    // ----------------------------------------------------------------
    logic sel;
    logic act;

    assign sel = (state_r != HS_IDLE);
    assign act = (state_r == HS_ACT);
    assign busy_out = sel;
    assign pins.e_host_oe = {3{bus_en_in}};
    assign pins.e_host_out = {!sel, !(act && is_wr_r),
                              !(act && !is_wr_r)};
    // Write data stands through setup, strobe and hold
    assign pins.d_host_out = wdata_r;
    assign pins.d_host_oe = {8{bus_en_in && sel && is_wr_r}};
endmodule : pdp_host

// [bench/pdp_asserts.sv]
/*
 * Checks on the pdp_if wires between the port device and the host.
 * Assumes one clock domain and a synchronous, active-high reset.
 */
`timescale 1ns/100ps
module pdp_asserts (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] d_dev_oe,
    input wire logic [7:0] d_host_oe,
    input wire logic [2:0] e_dev_oe,
    input wire logic [2:0] e_host_out,
    input wire logic [2:0] e_host_oe,
    input wire logic [2:0] e_level
);
    // ------------------------------------------------------------
    // Wire checks
    // ------------------------------------------------------------
    logic hon;

    // Host owns all strobes; a released host leaves them to the device or the pull-ups
    assign hon = (e_host_oe == 3'h7);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    a_reset_release: assert property ($fell(rst_in)
        |-> d_dev_oe == 8'h00 && e_dev_oe == 3'h0)
        else $error("pins driven after reset");
    a_wr_strobe_len: assert property (hon && $fell(e_host_out[1])
        |-> (!e_host_out[1])[*8] ##3 e_host_out[1])
        else $error("write strobe length");
    a_rd_strobe_len: assert property (hon && $fell(e_host_out[0])
        |-> (!e_host_out[0])[*8] ##3 e_host_out[0])
        else $error("read strobe length");
    a_select_setup: assert property (hon && $past(hon) &&
        ($fell(e_host_out[0]) || $fell(e_host_out[1]))
        |-> !e_host_out[2] && !$past(e_host_out[2], 2))
        else $error("select not set up before strobe");
    a_select_hold: assert property (hon && $past(hon) &&
        ($rose(e_host_out[0]) || $rose(e_host_out[1]))
        |-> !e_host_out[2] ##1 !e_host_out[2] ##1 e_host_out[2])
        else $error("select not held after strobe");
    a_strobe_excl: assert property (hon
        |-> e_host_out[1:0] != 2'b00)
        else $error("both strobes low");
    a_wr_data_held: assert property (hon && !e_host_out[1]
        |-> d_host_oe == 8'hFF)
        else $error("write data not driven");
    a_no_contention: assert property (d_host_oe != 8'h00
        |-> d_dev_oe == 8'h00)
        else $error("both ends drive port D");
    a_read_drive: assert property ($fell(e_level[0]) && !e_level[2]
        |-> ##[2:6] d_dev_oe == 8'hFF)
        else $error("device did not answer read");
    a_read_release: assert property ($rose(e_level[0]) && !e_level[2]
        |-> ##[1:6] d_dev_oe == 8'h00)
        else $error("device did not release port D");
endmodule : pdp_asserts

// [bench/tb_top.sv]
/*
 * Bench joining pdp_device and pdp_host through pdp_if.
 * Assumes the package, interface and design files compile first.
 */
`timescale 1ns/100ps
module tb_top;
    import pdp_pkg::*;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clock_in;
    logic rst_in;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic bus_en;
    logic h_wr;
    logic h_rd;
    logic [7:0] h_wdata;
    logic h_busy;
    logic [7:0] h_rdata;
    logic h_rdone;
    logic [7:0] got;
    int n_fail;
    int checks_done;

    pdp_if bus ();
    pdp_device i_pdp_device (.clock_in(clock_in), .rst_in(rst_in),
        .pins(bus), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata));
    pdp_host i_pdp_host (.clock_in(clock_in), .rst_in(rst_in),
        .pins(bus), .bus_en_in(bus_en), .wr_req_in(h_wr),
        .rd_req_in(h_rd), .wdata_in(h_wdata), .busy_out(h_busy),
        .rdata_out(h_rdata), .rdone_out(h_rdone));
    pdp_asserts i_pdp_asserts (.clock_in(clock_in), .rst_in(rst_in),
        .d_dev_oe(bus.d_dev_oe), .d_host_oe(bus.d_host_oe),
        .e_dev_oe(bus.e_dev_oe), .e_host_out(bus.e_host_out),
        .e_host_oe(bus.e_host_oe), .e_level(bus.e_level));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Strobe drops at the edge after it is raised, never twice a step
    task automatic cpu_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask : cpu_wr

    task automatic cpu_rd(input logic [2:0] a, input logic [7:0] exp,
                          input string name);
        @(posedge clock_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock_in);
        rd <= 1'b0;
        #1;
        chk(name, exp, rdata);
    endtask : cpu_rd

    // Pin filters need a few cycles before the level is visible
    task automatic settle;
        repeat (6) @(posedge clock_in);
        #1;
    endtask : settle

    task automatic host_xfer(input logic is_rd, input logic [7:0] d);
        int i;
        @(posedge clock_in);
        h_rd <= is_rd;
        h_wr <= !is_rd;
        h_wdata <= d;
        @(posedge clock_in);
        h_rd <= 1'b0;
        h_wr <= 1'b0;
        got = 8'h00;
        for (i = 0; i < 40; i++) begin
            @(posedge clock_in);
            #1;
            if (h_rdone === 1'b1) got = h_rdata;
            if (h_busy === 1'b0) break;
        end
        if (i == 40) begin
            n_fail++;
            $display("wrong value host_busy expected 0 seen 1");
        end
    endtask : host_xfer

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        cpu_rd(REG_E_CTRL, 8'h07, "ctrl");
        cpu_rd(REG_D_DIR, 8'hFF, "d_dir");
        cpu_rd(REG_E_PIN, 8'h00, "e_pin");
        cpu_rd(3'h7, 8'h00, "unmapped");
    endtask : t_reset

    task automatic t_port_d;
        cpu_wr(REG_D_LAT, 8'hA5);
        cpu_wr(REG_D_DIR, 8'h00);
        settle;
        chk("d_level", 8'hA5, bus.d_level);
        cpu_wr(REG_D_DIR, 8'hF0);
        settle;
        cpu_rd(REG_D_PIN, 8'hF5, "d_pin");
        cpu_rd(REG_D_LAT, 8'hA5, "d_lat");
        cpu_wr(REG_D_DIR, 8'hFF);
    endtask : t_port_d

    // Latch value keeps select high so no read strobe is ever formed
    task automatic t_port_e;
        cpu_wr(REG_E_LAT, 8'h04);
        cpu_wr(REG_E_CTRL, 8'h08);
        #1;
        chk("e_level", 8'h04, {5'h00, bus.e_level});
        cpu_rd(REG_E_CTRL, 8'h00, "ctrl_bit3");
        cpu_rd(REG_E_PIN, 8'h00, "e_pin_ana");
        cpu_wr(REG_ANA_CFG, 8'h07);
        settle;
        cpu_rd(REG_E_PIN, 8'h04, "e_pin_dig");
        cpu_rd(REG_E_LAT, 8'h04, "e_lat");
        cpu_wr(REG_E_CTRL, 8'hE6);
        #1;
        chk("e_level_in", 8'h06, {5'h00, bus.e_level});
        cpu_rd(REG_E_CTRL, 8'h06, "ctrl_ro");
        cpu_wr(REG_E_CTRL, 8'h07);
    endtask : t_port_e

    task automatic t_slave;
        @(posedge clock_in);
        bus_en <= 1'b1;
        host_xfer(1'b0, 8'h11);
        cpu_rd(REG_E_CTRL, 8'h07, "mode_off");
        cpu_wr(REG_E_CTRL, 8'h17);
        host_xfer(1'b0, 8'h3C);
        cpu_rd(REG_E_CTRL, 8'h97, "in_full");
        host_xfer(1'b0, 8'hC3);
        cpu_rd(REG_E_CTRL, 8'hB7, "overrun");
        cpu_rd(REG_D_PIN, 8'hC3, "rx_byte");
        cpu_rd(REG_E_CTRL, 8'h37, "full_clr");
        cpu_wr(REG_E_CTRL, 8'h37);
        cpu_rd(REG_E_CTRL, 8'h37, "ovr_keep");
        cpu_wr(REG_E_CTRL, 8'h17);
        cpu_rd(REG_E_CTRL, 8'h17, "ovr_clr");
        cpu_wr(REG_D_PIN, 8'h5A);
        cpu_rd(REG_E_CTRL, 8'h57, "out_pend");
        host_xfer(1'b1, 8'h00);
        chk("host_rd", 8'h5A, got);
        cpu_rd(REG_E_CTRL, 8'h17, "out_done");
    endtask : t_slave

    // Port E drives both strobes low itself while select stays high;
    // the device must take nothing and keep port D released
    task automatic t_cs_gate;
        cpu_wr(REG_D_DIR, 8'h00);
        cpu_wr(REG_E_CTRL, 8'h10);
        settle;
        chk("e_strobes", 8'h04, {5'h00, bus.e_level});
        chk("d_release", 8'hFF, bus.d_level);
        cpu_rd(REG_E_CTRL, 8'h10, "cs_gate");
        cpu_wr(REG_E_CTRL, 8'h17);
        cpu_wr(REG_D_DIR, 8'hFF);
    endtask : t_cs_gate

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // Clock, main sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    initial begin
        n_fail = 0;
        checks_done = 0;
        rst_in = 1'b1;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        bus_en = 1'b0;
        h_wr = 1'b0;
        h_rd = 1'b0;
        h_wdata = 8'h00;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        t_reset;
        t_port_d;
        t_port_e;
        t_slave;
        t_cs_gate;
        end_sim;
    end

    // Whole run is under two hundred cycles; this is ample margin
    initial begin
        #50000;
        n_fail++;
        $display("wrong value watchdog expected 0 seen 1");
        end_sim;
    end
endmodule : tb_top
